// ===== bcc_pkg.sv
// Package of constants and carriers for the buck converter control block
package bcc_pkg;
   localparam int CLK_HZ          = 200_000_000;
   localparam int SW_HZ           = 3_000_000;
   localparam int SW_PERIOD_CYC   = CLK_HZ / SW_HZ;
   localparam int PFM_ON_NS       = 100;
   localparam int PFM_ON_CYC      = (PFM_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int LEVEL_W         = 7;
   localparam int LEVEL_LSB       = 0;
   localparam int LEVEL_MSB       = 6;
   localparam int MODULES         = 9;
   localparam int MIN_UV          = 600_000;
   localparam int STEP_NUV        = 6_250;
   localparam int MAX_UV          = 1_400_000;
   localparam int CODE_MAX        = (MAX_UV - MIN_UV) / STEP_NUV;
   localparam logic [1:0] LIM_3A4 = 2'h0;
   localparam logic [1:0] LIM_4A0 = 2'h1;
   localparam logic [1:0] LIM_4A4 = 2'h2;
   localparam logic [1:0] LIM_5A0 = 2'h3;
   localparam logic [15:0] MA_3A4 = 16'hd48;
   localparam logic [15:0] MA_4A0 = 16'hfa0;
   localparam logic [15:0] MA_4A4 = 16'h1130;
   localparam logic [15:0] MA_5A0 = 16'h1388;

   typedef struct packed {
      logic [LEVEL_W-1:0] level_code;
      logic               force_pwm;
      logic               enable;
   } bcc_setpoint_s;

   typedef struct packed {
      logic [MODULES-1:0] module_en;
      logic [1:0]         peak_limit_code;
   } bcc_stage_s;

   typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} bcc_phase_e;
endpackage

// ===== bcc_pulse.sv
// Switching-cycle timer: 3 MHz tick plus cycle position
`timescale 1ns/100ps
module bcc_pulse (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   output logic            tick_o,
   output logic [7:0]      pos_o
);
   import bcc_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } bcc_tmr_s;

   bcc_tmr_s q, next_q;

   always_comb begin
      next_q = q;
      next_q.tick = 1'b0;
      if (q.cnt == 8'(SW_PERIOD_CYC - 1)) begin
         next_q.cnt  = 8'h00;
         next_q.tick = 1'b1;
      end else begin
         next_q.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick_o = q.tick;
   assign pos_o  = q.cnt;

   period_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      q.tick |-> ##(SW_PERIOD_CYC) q.tick) else $error("switching tick period wrong");
endmodule // bcc_pulse

// ===== bcc_top.sv
// Buck converter digital control: set-point select, mode and switch drive
//
// Operation
// - Set-point A is used only when the gate bit is 1 and the select pin low, else set-point B.
// - A level code means 0.6 V plus 6.25 mV per step, up to 1.4 V.
// - Each level field is seven bits, bits 6..0, and a new write takes effect at once if active.
// - While the active set-point forces PWM the controller never enters PFM.
// - Without forced PWM the controller goes to PFM on discontinuous current and back on continuous.
// - In PWM the switch runs from a fixed 3 MHz clock and regulates by duty cycle.
// - In PFM the high-side on-time is fixed, frequency varies, and low side rectifies after each pulse.
// - In PWM the low side is the complement of the high side while the converter is enabled.
// - Nine output-stage modules each have their own enable bit.
// - Peak limit code 00/01/10/11 selects 3.4/4.0/4.4/5.0 A.
// - The high-side pulse is cut short whenever inductor current reaches the peak threshold.
// - Register defaults are constant at reset and are replaced by factory-programmed settings on fuse_load_i.
// - The select pin switches level and enable with no host latency; the mode follows only at the next switching tick.
`timescale 1ns/100ps
module bcc_top #(
   parameter int MODULES_P = bcc_pkg::MODULES
) (
   input  wire logic                  clk_i,
   input  wire logic                  arst_n_i,
   input  wire logic                  setpoint_select_pin_i,
   input  wire logic                  select_gate_bit_i,
   input  wire bcc_pkg::bcc_setpoint_s setpoint_a_i,
   input  wire bcc_pkg::bcc_setpoint_s setpoint_b_i,
   input  wire bcc_pkg::bcc_stage_s   stage_i,
   input  wire bcc_pkg::bcc_setpoint_s fuse_a_i,
   input  wire bcc_pkg::bcc_setpoint_s fuse_b_i,
   input  wire bcc_pkg::bcc_stage_s   fuse_stage_i,
   input  wire logic                  fuse_load_i,
   input  wire logic                  cfg_written_i,
   input  wire logic                  duty_end_i,
   input  wire logic                  need_pulse_i,
   input  wire logic                  current_dcm_i,
   input  wire logic [15:0]           inductor_ma_i,
   output logic                       high_side_o,
   output logic                       low_side_o,
   output logic                       pfm_o,
   output logic [MODULES_P-1:0]       module_en_o,
   output logic [bcc_pkg::LEVEL_W-1:0] level_code_o,
   output logic [20:0]                level_uv_o,
   output logic [15:0]                peak_ma_o,
   output logic                       conv_en_o
);
   import bcc_pkg::*;

   // ************************************************
   // Decoders
   // ************************************************
   function automatic logic [15:0] peak_ma(input logic [1:0] code);
      case (code)
         LIM_3A4: peak_ma = MA_3A4;
         LIM_4A0: peak_ma = MA_4A0;
         LIM_4A4: peak_ma = MA_4A4;
         default: peak_ma = MA_5A0;
      endcase
   endfunction

   // Top of range needs 21 bits of microvolts
   function automatic logic [20:0] code_uv(input logic [LEVEL_W-1:0] code);
      logic [20:0] uv;
      uv = 21'(MIN_UV) + 21'(code) * 21'(STEP_NUV);
      if (uv > 21'(MAX_UV)) begin
         uv = 21'(MAX_UV);
      end
      code_uv = uv;
   endfunction

   // ************************************************
   // State
   // ************************************************
   typedef struct packed {
      bcc_setpoint_s        sp_a;
      bcc_setpoint_s        sp_b;
      bcc_stage_s           stage;
      logic                 use_a;
      logic                 pfm;
      logic [MODULES_P-1:0] mod_en;
      logic [1:0]           lim;
      bcc_phase_e           phase;
      logic [7:0]           on_cnt;
      logic                 hs;
      logic                 ls;
      logic [LEVEL_W-1:0]   level;
      logic [20:0]          uv;
      logic [15:0]          pk;
      logic                 en;
   } bcc_state_s;

   bcc_state_s    q, next_q;
   logic          tick;
   bcc_setpoint_s act;
   logic          over;

   bcc_pulse u_pulse (
      .clk_i   (clk_i),
      .arst_n_i(arst_n_i),
      .tick_o  (tick),
      .pos_o   ()
   );

   always_comb begin
      next_q = q;
      // Factory values replace the constant reset defaults
      if (fuse_load_i) begin
         next_q.sp_a  = fuse_a_i;
         next_q.sp_b  = fuse_b_i;
         next_q.stage = fuse_stage_i;
      end else if (cfg_written_i) begin
         next_q.sp_a  = setpoint_a_i;
         next_q.sp_b  = setpoint_b_i;
         next_q.stage = stage_i;
      end
      // Pin path is combinational into one flop: no host latency
      next_q.use_a = select_gate_bit_i && !setpoint_select_pin_i;
      act   = q.use_a ? q.sp_a : q.sp_b;
      over  = inductor_ma_i >= q.pk;
      next_q.level = act.level_code[LEVEL_MSB:LEVEL_LSB];
      next_q.uv    = code_uv(act.level_code);
      next_q.en    = act.enable;
      // Mixed settings within a PWM pulse are avoided by latching on the tick
      if (tick) begin
         next_q.mod_en = q.stage.module_en[MODULES_P-1:0];
         next_q.lim    = q.stage.peak_limit_code;
         next_q.pk     = peak_ma(q.stage.peak_limit_code);
         if (act.force_pwm) begin
            next_q.pfm = 1'b0;
         end else begin
            next_q.pfm = current_dcm_i;
         end
      end
      case (q.phase)
         ST_IDLE: begin
            next_q.hs = 1'b0;
            next_q.ls = q.pfm ? 1'b0 : q.en;
            if (q.en && !over && ((!q.pfm && tick) || (q.pfm && need_pulse_i))) begin
               next_q.phase  = ST_HIGH;
               next_q.hs     = 1'b1;
               next_q.ls     = 1'b0;
               next_q.on_cnt = 8'h00;
            end
         end
         ST_HIGH: begin
            next_q.on_cnt = q.on_cnt + 8'h01;
            if (over || !q.en || (!q.pfm && duty_end_i) || (q.pfm && q.on_cnt ==
                8'(PFM_ON_CYC - 1))) begin
               next_q.hs    = 1'b0;
               next_q.ls    = q.en;
               next_q.phase = q.pfm ? ST_LOW : ST_IDLE;
            end
         end
         ST_LOW: begin
            // Synchronous rectifier until current returns to zero
            next_q.hs = 1'b0;
            next_q.ls = !current_dcm_i && q.en;
            // Heavy load never reaches zero current: PWM takes over here
            if (current_dcm_i || !q.en || !q.pfm) begin
               next_q.phase = ST_IDLE;
            end
         end
         default: begin
            next_q.phase = ST_IDLE;
            next_q.hs    = 1'b0;
            next_q.ls    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q       <= '0;
         q.phase <= ST_IDLE;
         q.pk    <= MA_3A4;
         q.uv    <= 21'(MIN_UV);
      end else begin
         q <= next_q;
      end
   end

   assign high_side_o  = q.hs;
   assign low_side_o   = q.ls;
   assign pfm_o        = q.pfm;
   assign module_en_o  = q.mod_en;
   assign level_code_o = q.level;
   assign level_uv_o   = q.uv;
   assign peak_ma_o    = q.pk;
   assign conv_en_o    = q.en;

   // ************************************************
   // Checks
   // ************************************************
   select_path_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ##2 level_code_o == ($past(select_gate_bit_i, 2) && !$past(setpoint_select_pin_i, 2) ?
      $past(q.sp_a.level_code) : $past(q.sp_b.level_code))) else $error("wrong set-point");
   no_overlap_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !(high_side_o && low_side_o)) else $error("both switches on");
   force_pwm_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (tick && q.use_a && q.sp_a.force_pwm) |=> !pfm_o) else $error("PFM while forced");
   mode_edge_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $changed(pfm_o) |-> $past(tick)) else $error("mode changed mid-cycle");
   peak_cut_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (q.phase == ST_HIGH && over) |=> !high_side_o) else $error("peak not cut");
   pfm_width_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (pfm_o && conv_en_o && q.phase == ST_HIGH && q.on_cnt == 8'(PFM_ON_CYC - 1)) |=>
      (!high_side_o && low_side_o)) else $error("PFM on-time wrong");
   pwm_low_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ($fell(high_side_o) && !pfm_o && conv_en_o) |-> low_side_o) else $error("no complement");
   code_volt_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      level_uv_o == 21'(MIN_UV) + 21'(level_code_o) * 21'(STEP_NUV)) else $error("level scale");
   limit_map_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (tick && q.stage.peak_limit_code == LIM_4A4) |=> peak_ma_o == MA_4A4)
      else $error("limit decode");
   mod_edge_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $changed(module_en_o) |-> $past(tick)) else $error("module enable mid-cycle");
   cv_pfm_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(pfm_o));
   cv_pwm_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      $fell(high_side_o) && low_side_o && !pfm_o);
   cv_sel_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) $changed(q.use_a));
   cv_cut_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      q.phase == ST_HIGH && over);
endmodule // bcc_top

// ===== bcc_stage_model.sv
// Behavioural power stage and load model facing the converter control
`timescale 1ns/100ps
module bcc_stage_model #(
   parameter int DUTY_P = 50
) (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        high_side_i,
   input  wire logic        light_load_i,
   output logic             duty_end_o,
   output logic             need_pulse_o,
   output logic             current_dcm_o,
   output logic [15:0]      inductor_ma_o
);
   int on_cnt;
   // Ramp 100 mA a cycle, so a long duty always meets the peak limit
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         on_cnt <= 0;
         inductor_ma_o <= 16'h0;
      end else if (high_side_i) begin
         on_cnt <= on_cnt + 1;
         inductor_ma_o <= inductor_ma_o + 16'h64;
      end else begin
         on_cnt <= 0;
         inductor_ma_o <= 16'h0;
      end
   end
   assign duty_end_o    = high_side_i && (on_cnt == DUTY_P);
   // Light load means discontinuous current and a steady call for pulses
   assign need_pulse_o  = light_load_i;
   assign current_dcm_o = light_load_i;
endmodule // bcc_stage_model

// ===== tb.sv
// Self-checking testbench of the buck converter control block
`timescale 1ns/100ps
module tb;
   import bcc_pkg::*;
   logic clk_i, arst_n, pin, gate, fload, cfg_wr, light, duty, need, dcm;
   logic hs, ls, pfm, cen;
   bcc_setpoint_s sp_a, sp_b, fa, fb;
   bcc_stage_s    stg, fst;
   logic [15:0]   ima, peak;
   logic [8:0]    men;
   logic [6:0]    lvl;
   logic [20:0]   uv;
   int num_errors = 0;
   int checks = 0;
   // ***************
   // Clock and parts
   // ***************
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   bcc_top DUT (.clk_i(clk_i), .arst_n_i(arst_n), .setpoint_select_pin_i(pin),
      .select_gate_bit_i(gate), .setpoint_a_i(sp_a), .setpoint_b_i(sp_b), .stage_i(stg),
      .fuse_a_i(fa), .fuse_b_i(fb), .fuse_stage_i(fst), .fuse_load_i(fload),
      .cfg_written_i(cfg_wr), .duty_end_i(duty), .need_pulse_i(need), .current_dcm_i(dcm),
      .inductor_ma_i(ima), .high_side_o(hs), .low_side_o(ls), .pfm_o(pfm),
      .module_en_o(men), .level_code_o(lvl), .level_uv_o(uv), .peak_ma_o(peak),
      .conv_en_o(cen));
   bcc_stage_model u_stage (.clk_i(clk_i), .arst_n_i(arst_n), .high_side_i(hs),
      .light_load_i(light), .duty_end_o(duty), .need_pulse_o(need), .current_dcm_o(dcm),
      .inductor_ma_o(ima));
   // *****
   // Tasks
   // *****
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input bcc_setpoint_s a, input bcc_setpoint_s b, input bcc_stage_s s);
      sp_a = a;
      sp_b = b;
      stg = s;
      cfg_wr = 1'b1;
      step(1);
      cfg_wr = 1'b0;
      step(3);
   endtask
   task end_of_test;
      if (num_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic t_reset;
      check("peak_rst", peak, 32'hd48);
      check("lvl_rst", lvl, 32'h0);
      fload = 1'b1;
      step(1);
      fload = 1'b0;
      step(70);
      check("lvl_fuse", lvl, 32'h11);
      check("men_fuse", men, 32'h0f3);
      check("peak_fuse", peak, 32'h1130);
   endtask
   task automatic t_select;
      logic use_a;
      wr({7'h05, 1'b0, 1'b1}, {7'h7f, 1'b0, 1'b0}, {9'h1ff, 2'h0});
      for (int i = 0; i < 4; i++) begin
         {pin, gate} = i[1:0];
         step(2);
         use_a = gate && !pin;
         check("lvl_sel", lvl, use_a ? 32'h05 : 32'h7f);
         check("en_sel", cen, {31'h0, use_a});
         check("uv_sel", uv, use_a ? 32'd631250 : 32'd1393750);
      end
      // Later scenarios run from set-point A
      {pin, gate} = 2'b01;
      wr({7'h2a, 1'b0, 1'b1}, {7'h7f, 1'b0, 1'b0}, {9'h1ff, 2'h0});
      check("lvl_wr", lvl, 32'h2a);
   endtask
   task automatic t_limit;
      logic [15:0] ma [4] = '{16'hd48, 16'hfa0, 16'h1130, 16'h1388};
      logic [8:0]  mods [4] = '{9'h1ff, 9'h001, 9'h155, 9'h100};
      for (int k = 0; k < 4; k++) begin
         wr(sp_a, sp_b, {mods[k], k[1:0]});
         step(70);
         check("peak_code", peak, {16'h0, ma[k]});
         check("modules", men, {23'h0, mods[k]});
      end
   endtask
   task automatic t_mode;
      int w;
      int n;
      light = 1'b1;
      wr({7'h10, 1'b1, 1'b1}, sp_b, {9'h1ff, 2'h3});
      step(70);
      check("pfm_forced", pfm, 32'h0);
      wr({7'h10, 1'b0, 1'b1}, sp_b, stg);
      step(70);
      check("pfm_light", pfm, 32'h1);
      w = 0;
      n = 0;
      // Skip a pulse already under way so a whole one is timed
      while (hs && w < 300) begin
         step(1);
         w++;
      end
      while (!hs && w < 300) begin
         step(1);
         w++;
      end
      while (hs && n < 300) begin
         step(1);
         n++;
      end
      check("pfm_on", n, PFM_ON_CYC);
      check("pfm_rect", ls, 32'h1);
      light = 1'b0;
      step(70);
      check("pfm_heavy", pfm, 32'h0);
   endtask
   task automatic t_pwm;
      int rises;
      int bad;
      int on;
      int mx;
      logic prev;
      rises = 0;
      bad = 0;
      on = 0;
      mx = 0;
      wr({7'h10, 1'b1, 1'b1}, sp_b, {9'h1ff, 2'h0});
      step(70);
      // 198 edges seen: exactly three switching periods
      prev = hs;
      for (int c = 0; c < 199; c++) begin
         if (hs && !prev) rises++;
         if (ls !== !hs) bad++;
         on = hs ? on + 1 : 0;
         if (on > mx) mx = on;
         prev = hs;
         step(1);
      end
      check("pwm_rises", rises, 32'd3);
      check("complement", bad, 32'h0);
      check("peak_cut", {31'h0, mx >= 34 && mx <= 36}, 32'h1);
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      {arst_n, pin, gate, fload, cfg_wr, light} = 6'h08;
      {sp_a, sp_b, stg} = '0;
      fa = {7'h11, 1'b0, 1'b1};
      fb = {7'h21, 1'b0, 1'b1};
      fst = {9'h0f3, 2'h2};
      step(4);
      arst_n = 1'b1;
      t_reset;
      t_select;
      t_limit;
      t_mode;
      t_pwm;
      end_of_test;
   end
   // Cut a hang well past the expected run of about 900 cycles
   initial begin
      repeat (4000) @(posedge clk_i);
      num_errors++;
      end_of_test;
   end
endmodule // tb
